/* File: pcsia_core.sv */
// Contract
// RULE1 - counter advances by one each cycle unless instruction loads it
// RULE2 - jump loads counter bits 8:0 from instruction address field
// RULE3 - jump takes counter bit 9 from page preselect bit
// RULE4 - low byte register reads and writes counter bits 7:0
// RULE5 - call or low-byte write loads bits 7:0, clears bit 8
// RULE6 - move, add or bit set to low byte acts as computed jump
// RULE7 - reset sets counter to all ones
// RULE8 - after reset location, counter wraps to zero
// RULE9 - reset clears page preselect bit
// RULE10 - return stack two entries of twelve bits
// RULE11 - call copies level one to two, pushes counter plus one
// RULE12 - deeper nesting keeps only two newest returns, no indication
// RULE13 - literal return loads counter from level one, level two to one
// RULE14 - literal return loads accumulator with instruction literal
// RULE15 - repeated returns reuse last level two address
// RULE16 - no stack overflow or underflow flag
// RULE17 - indirect data port redirects to register addressed by pointer
// RULE18 - indirect read with pointer zero returns zero
// RULE19 - indirect write to itself changes no register
// RULE20 - pointer bits 4:0 select location 00h to 1Fh
// RULE21 - page preselect chooses page 0 or page 1 of 512
// RULE22 - calls and computed jumps also take bit 9 from page bit
`default_nettype none
module pcsia_core (
	input wire logic I_SYS_CLK,
	input wire logic I_SRST,
	input wire logic I_CYCLE_EN,
	input wire pcsia_pkg::pcsia_op_t I_OP,
	input wire logic [8:0] I_OPERAND,
	input wire logic [pcsia_pkg::DATA_W-1:0] I_LOW_BYTE_DATA,
	input wire logic I_PAGE_WRITE,
	input wire logic I_PAGE_VALUE,
	input wire logic I_POINTER_WRITE,
	input wire logic [pcsia_pkg::DATA_W-1:0] I_POINTER_DATA,
	input wire logic I_IND_READ,
	input wire logic I_IND_WRITE,
	input wire logic [pcsia_pkg::DATA_W-1:0] I_IND_WDATA,
	input wire logic [pcsia_pkg::DATA_W-1:0] I_FILE_RDATA,
	output logic [pcsia_pkg::PC_W-1:0] O_PC,
	output logic [pcsia_pkg::DATA_W-1:0] O_PROGRAM_COUNTER_LOW_BYTE,
	output logic O_PAGE_PRESELECT_BIT,
	output logic [pcsia_pkg::DATA_W-1:0] O_ACC,
	output logic O_ACC_LOAD,
	output logic [pcsia_pkg::DATA_W-1:0] O_INDIRECT_POINTER,
	output logic [pcsia_pkg::ADDR_W-1:0] O_FILE_ADDR,
	output logic O_FILE_WE,
	output logic [pcsia_pkg::DATA_W-1:0] O_FILE_WDATA,
	output logic [pcsia_pkg::DATA_W-1:0] O_IND_RDATA
);
	logic [pcsia_pkg::PC_W-1:0] pc_ff;
	logic [pcsia_pkg::PC_W-1:0] nxt_pc;
	logic page_ff;
	logic [pcsia_pkg::DATA_W-1:0] pointer_ff;
	logic [pcsia_pkg::DATA_W-1:0] acc_ff;
	logic acc_load_ff;
	logic [pcsia_pkg::ADDR_W-1:0] file_addr_ff;
	logic file_we_ff;
	logic [pcsia_pkg::DATA_W-1:0] file_wdata_ff;
	logic [pcsia_pkg::DATA_W-1:0] ind_rdata_ff;
	logic [pcsia_pkg::ADDR_W-1:0] ind_addr;
	logic ind_self;
	logic [pcsia_pkg::PC_W-1:0] pc_plus1;
	pcsia_stack_if stk ();

	pcsia_stack u_stack (
		.i_clk(I_SYS_CLK),
		.i_srst(I_SRST),
		.s(stk.stack)
	);

	// ----------------------------------------
	// counter next value
	// ----------------------------------------
	// natural wrap of 3ffh+1 gives 000h [RULE8]
	assign pc_plus1 = pc_ff + 10'h001;

	always_comb begin
		nxt_pc = pc_plus1; // [RULE1]
		case (I_OP)
			pcsia_pkg::PCSIA_OP_JUMP: begin
				nxt_pc = {page_ff, I_OPERAND}; // [RULE2] [RULE3] [RULE21]
			end
			pcsia_pkg::PCSIA_OP_CALL: begin
				nxt_pc = {page_ff, 1'b0, I_OPERAND[7:0]}; // [RULE5] [RULE22]
			end
			pcsia_pkg::PCSIA_OP_LOW_WRITE: begin
				// computed jump; limited to first 256 words of a page
				nxt_pc = {page_ff, 1'b0, I_LOW_BYTE_DATA}; // [RULE4] [RULE5] [RULE6] [RULE22]
			end
			pcsia_pkg::PCSIA_OP_LITERAL_RETURN: begin
				nxt_pc = stk.top[pcsia_pkg::PC_W-1:0]; // [RULE13]
			end
			default: begin
				nxt_pc = pc_plus1;
			end
		endcase
	end

	// ----------------------------------------
	// stack control
	// ----------------------------------------
	assign stk.push = I_CYCLE_EN && (I_OP == pcsia_pkg::PCSIA_OP_CALL); // [RULE11]
	assign stk.pop = I_CYCLE_EN && (I_OP == pcsia_pkg::PCSIA_OP_LITERAL_RETURN); // [RULE13]
	assign stk.push_value = {2'b00, pc_plus1}; // [RULE11]

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			pc_ff <= pcsia_pkg::PC_RESET; // [RULE7]
		end else if (I_CYCLE_EN) begin
			pc_ff <= nxt_pc;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			page_ff <= 1'b0; // [RULE9]
		end else if (I_CYCLE_EN && I_PAGE_WRITE) begin
			page_ff <= I_PAGE_VALUE;
		end
	end

	// ----------------------------------------
	// literal return accumulator
	// ----------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			acc_ff <= pcsia_pkg::ACC_RESET;
			acc_load_ff <= 1'b0;
		end else begin
			acc_load_ff <= stk.pop;
			if (stk.pop) begin
				acc_ff <= I_OPERAND[7:0]; // [RULE14]
			end
		end
	end

	// ----------------------------------------
	// indirect addressing
	// ----------------------------------------
	assign ind_addr = pointer_ff[pcsia_pkg::ADDR_W-1:0]; // [RULE20]
	assign ind_self = (ind_addr == pcsia_pkg::INDIRECT_PORT_ADDR);

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			pointer_ff <= pcsia_pkg::POINTER_RESET;
		end else if (I_CYCLE_EN && I_POINTER_WRITE) begin
			pointer_ff <= I_POINTER_DATA;
		end
	end

	// port holds nothing; all traffic except with pointer bits 4:0 at 00h goes to the file [RULE17]
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			file_addr_ff <= {pcsia_pkg::ADDR_W{1'b0}};
			file_we_ff <= 1'b0;
			file_wdata_ff <= {pcsia_pkg::DATA_W{1'b0}};
		end else begin
			file_addr_ff <= ind_addr; // [RULE17]
			file_we_ff <= I_CYCLE_EN && I_IND_WRITE && !ind_self; // [RULE19]
			file_wdata_ff <= I_IND_WDATA;
		end
	end

	// read data from same-clock file, registered one cycle later
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			ind_rdata_ff <= pcsia_pkg::SELF_READ_VALUE;
		end else if (I_IND_READ) begin
			ind_rdata_ff <= ind_self ? pcsia_pkg::SELF_READ_VALUE : I_FILE_RDATA; // [RULE18] [RULE17]
		end
	end

	assign O_PC = pc_ff;
	assign O_PROGRAM_COUNTER_LOW_BYTE = pc_ff[7:0]; // [RULE4]
	assign O_PAGE_PRESELECT_BIT = page_ff;
	assign O_ACC = acc_ff;
	assign O_ACC_LOAD = acc_load_ff;
	assign O_INDIRECT_POINTER = pointer_ff;
	assign O_FILE_ADDR = file_addr_ff;
	assign O_FILE_WE = file_we_ff;
	assign O_FILE_WDATA = file_wdata_ff;
	assign O_IND_RDATA = ind_rdata_ff;
endmodule
`default_nettype wire

/* File: pcsia_pkg.sv */
`default_nettype none
package pcsia_pkg;
	localparam int PC_W = 10;
	localparam int STK_W = 12;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 5;
	localparam int PAGE_BIT = 9;
	localparam int BIT8 = 8;
	localparam int STATUS_PAGE_POS = 5;
	localparam logic [PC_W-1:0] PC_RESET = 10'h3ff;
	localparam logic [ADDR_W-1:0] INDIRECT_PORT_ADDR = 5'h00;
	localparam logic [DATA_W-1:0] SELF_READ_VALUE = 8'h00;
	localparam logic [STK_W-1:0] STACK_RESET = 12'h000;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [DATA_W-1:0] POINTER_RESET = 8'h00;
	typedef enum logic [2:0] {
		PCSIA_OP_NONE,
		PCSIA_OP_JUMP,
		PCSIA_OP_CALL,
		PCSIA_OP_LOW_WRITE,
		PCSIA_OP_LITERAL_RETURN
	} pcsia_op_t;
endpackage
`default_nettype wire

/* File: pcsia_stack_if.sv */
`default_nettype none
interface pcsia_stack_if;
	logic push;
	logic pop;
	logic [pcsia_pkg::STK_W-1:0] push_value;
	logic [pcsia_pkg::STK_W-1:0] top;
	modport core (output push, output pop, output push_value, input top);
	modport stack (input push, input pop, input push_value, output top);
endinterface
`default_nettype wire

/* File: pcsia_stack.sv */
`default_nettype none
module pcsia_stack (
	input wire logic i_clk,
	input wire logic i_srst,
	pcsia_stack_if.stack s
);
	logic [pcsia_pkg::STK_W-1:0] level1_ff;
	logic [pcsia_pkg::STK_W-1:0] level2_ff;
	// ----------------------------------------
	// two-level stack
	// ----------------------------------------
	// no depth counter: overflow silently drops level two [RULE12] [RULE16]
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			level1_ff <= pcsia_pkg::STACK_RESET;
			level2_ff <= pcsia_pkg::STACK_RESET;
		end else if (s.push) begin
			level2_ff <= level1_ff; // [RULE11] [RULE10]
			level1_ff <= s.push_value; // [RULE11]
		end else if (s.pop) begin
			level1_ff <= level2_ff; // level two kept, so underflow repeats it [RULE13] [RULE15]
		end
	end
	assign s.top = level1_ff;
endmodule
`default_nettype wire

/* File: pcsia_file_model.sv */
`default_nettype none
module pcsia_file_model (
	input wire logic i_clk,
	input wire logic [4:0] i_addr,
	input wire logic i_we,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	// cells start unknown so a read that was never written cannot match
	logic [7:0] mem_ff [32];
	always @(posedge i_clk) if (i_we) mem_ff[i_addr] <= i_wdata;
	assign o_rdata = mem_ff[i_addr];
endmodule
`default_nettype wire

/* File: pcsia_chk.sv */
`default_nettype none
module pcsia_chk (
	input wire logic I_SYS_CLK,
	input wire logic I_SRST,
	input wire logic I_CYCLE_EN,
	input wire pcsia_pkg::pcsia_op_t I_OP,
	input wire logic [8:0] I_OPERAND,
	input wire logic I_PAGE_WRITE,
	input wire logic I_IND_READ,
	input wire logic I_IND_WRITE,
	input wire logic [9:0] O_PC,
	input wire logic O_PAGE_PRESELECT_BIT,
	input wire logic [7:0] O_ACC,
	input wire logic O_ACC_LOAD,
	input wire logic [7:0] O_INDIRECT_POINTER,
	input wire logic [4:0] O_FILE_ADDR,
	input wire logic O_FILE_WE,
	input wire logic [7:0] O_IND_RDATA
);
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (I_SRST);
	logic p0;
	logic en;
	assign p0 = O_INDIRECT_POINTER[4:0] == 5'h00;
	// a page write in the same cycle is left out: the load takes the page bit held before the write
	assign en = I_CYCLE_EN && !I_PAGE_WRITE;
	pc_step_a: assert property (
		en && I_OP == pcsia_pkg::PCSIA_OP_NONE |=> O_PC == $past(O_PC) + 10'h001) else $error("pc step");
	pc_hold_a: assert property (
		!I_CYCLE_EN |=> $stable(O_PC)) else $error("pc hold");
	pc_reset_a: assert property (
		disable iff (1'b0) I_SRST |=> O_PC == 10'h3ff && !O_PAGE_PRESELECT_BIT) else $error("reset");
	jump_load_a: assert property (
		en && I_OP == pcsia_pkg::PCSIA_OP_JUMP |=> O_PC == {$past(O_PAGE_PRESELECT_BIT), $past(I_OPERAND)})
		else $error("jump");
	call_load_a: assert property (
		en && I_OP == pcsia_pkg::PCSIA_OP_CALL |=> O_PC == {$past(O_PAGE_PRESELECT_BIT), 1'b0, $past(I_OPERAND[7:0])})
		else $error("call");
	acc_load_a: assert property (
		en && I_OP == pcsia_pkg::PCSIA_OP_LITERAL_RETURN |=> O_ACC_LOAD && O_ACC == $past(I_OPERAND[7:0]))
		else $error("acc");
	self_write_a: assert property (
		I_CYCLE_EN && I_IND_WRITE && p0 |=> !O_FILE_WE) else $error("self write");
	file_write_a: assert property (
		I_CYCLE_EN && I_IND_WRITE && !p0 |=> O_FILE_WE && O_FILE_ADDR == $past(O_INDIRECT_POINTER[4:0]))
		else $error("file write");
	self_read_a: assert property (
		I_IND_READ && p0 |=> O_IND_RDATA == 8'h00) else $error("self read");
	cover property (O_FILE_WE);
	cover property (O_ACC_LOAD);
	cover property (I_IND_READ && p0);
	// three calls in a row: the overflow case
	cover property (I_CYCLE_EN && I_OP == pcsia_pkg::PCSIA_OP_CALL ##1 I_CYCLE_EN && I_OP == pcsia_pkg::PCSIA_OP_CALL
		##1 I_CYCLE_EN && I_OP == pcsia_pkg::PCSIA_OP_CALL);
endmodule
bind pcsia_core pcsia_chk i_chk (.*);
`default_nettype wire

/* File: tb_top.sv */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic I_SYS_CLK, I_SRST, I_CYCLE_EN, I_PAGE_WRITE, I_PAGE_VALUE, I_POINTER_WRITE, I_IND_READ, I_IND_WRITE;
	pcsia_pkg::pcsia_op_t I_OP;
	logic [8:0] I_OPERAND;
	logic [7:0] I_LOW_BYTE_DATA, I_POINTER_DATA, I_IND_WDATA, I_FILE_RDATA;
	logic [9:0] O_PC;
	logic O_PAGE_PRESELECT_BIT, O_ACC_LOAD, O_FILE_WE;
	logic [7:0] O_PROGRAM_COUNTER_LOW_BYTE, O_ACC, O_INDIRECT_POINTER, O_FILE_WDATA, O_IND_RDATA;
	logic [4:0] O_FILE_ADDR;
	int num_errors = 0;
	int samples_checked = 0;
	pcsia_core i_dut (.*);
	pcsia_file_model i_file (.i_clk(I_SYS_CLK), .i_addr(O_FILE_ADDR), .i_we(O_FILE_WE), .i_wdata(O_FILE_WDATA),
		.o_rdata(I_FILE_RDATA));
	initial begin
		I_SYS_CLK = 1'b0;
		forever #12.5 I_SYS_CLK = ~I_SYS_CLK;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic end_sim();
		if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// strobes: 8 page write, 4 pointer write, 2 indirect read, 1 indirect write
	// each set once per cycle, so no strobe is assigned twice in one time step
	task automatic cy(input pcsia_pkg::pcsia_op_t o = pcsia_pkg::PCSIA_OP_NONE, input logic [8:0] d = 9'h000,
		input logic [3:0] s = 4'h0);
		I_OP = o;
		I_OPERAND = d;
		{I_PAGE_WRITE, I_POINTER_WRITE, I_IND_READ, I_IND_WRITE} = s;
		@(posedge I_SYS_CLK);
		#2;
	endtask
	task automatic t_flow();
		chk(O_PC, 10'h3ff);
		chk(O_PAGE_PRESELECT_BIT, 1'b0);
		cy();
		chk(O_PC, 10'h000);
		cy();
		chk(O_PC, 10'h001);
		I_CYCLE_EN = 1'b0;
		cy(pcsia_pkg::PCSIA_OP_JUMP, 9'h155);
		chk(O_PC, 10'h001);
		I_CYCLE_EN = 1'b1;
		cy(pcsia_pkg::PCSIA_OP_JUMP, 9'h1ab);
		chk(O_PC, 10'h1ab);
		I_PAGE_VALUE = 1'b1;
		cy(pcsia_pkg::PCSIA_OP_NONE, 9'h000, 4'h8);
		chk(O_PAGE_PRESELECT_BIT, 1'b1);
		cy(pcsia_pkg::PCSIA_OP_JUMP, 9'h0cd);
		chk(O_PC, 10'h2cd);
	endtask
	// three nested calls overflow the two levels: the oldest return is lost
	task automatic t_stack();
		cy(pcsia_pkg::PCSIA_OP_CALL, 9'h045);
		chk(O_PC, 10'h245);
		cy(pcsia_pkg::PCSIA_OP_CALL, 9'h1ff);
		chk(O_PC, 10'h2ff);
		cy(pcsia_pkg::PCSIA_OP_CALL, 9'h010);
		cy(pcsia_pkg::PCSIA_OP_LITERAL_RETURN, 9'h033);
		chk(O_PC, 10'h300);
		chk({O_ACC_LOAD, O_ACC}, 9'h133);
		cy(pcsia_pkg::PCSIA_OP_LITERAL_RETURN, 9'h000);
		chk(O_PC, 10'h246);
		cy(pcsia_pkg::PCSIA_OP_LITERAL_RETURN, 9'h000);
		chk(O_PC, 10'h246);
	endtask
	task automatic t_low();
		I_LOW_BYTE_DATA = 8'h80;
		cy(pcsia_pkg::PCSIA_OP_LOW_WRITE, 9'h000);
		chk(O_PC, 10'h280);
		chk(O_PROGRAM_COUNTER_LOW_BYTE, 8'h80);
		I_PAGE_VALUE = 1'b0;
		cy(pcsia_pkg::PCSIA_OP_NONE, 9'h000, 4'h8);
		I_LOW_BYTE_DATA = 8'hfe;
		cy(pcsia_pkg::PCSIA_OP_LOW_WRITE, 9'h000);
		chk(O_PC, 10'h0fe);
	endtask
	task automatic ind(input logic [7:0] p, input logic [7:0] w, input logic we, input logic [7:0] r);
		I_POINTER_DATA = p;
		cy(pcsia_pkg::PCSIA_OP_NONE, 9'h000, 4'h4);
		chk(O_INDIRECT_POINTER, p);
		I_IND_WDATA = w;
		cy(pcsia_pkg::PCSIA_OP_NONE, 9'h000, 4'h1);
		chk(O_FILE_WE, we);
		chk({O_FILE_ADDR, O_FILE_WDATA}, {p[4:0], w});
		// one idle cycle lets the file take the write before it is read back
		cy();
		cy(pcsia_pkg::PCSIA_OP_NONE, 9'h000, 4'h2);
		chk(O_IND_RDATA, r);
	endtask
	// reset in mid-run with page one selected
	task automatic t_rst();
		I_PAGE_VALUE = 1'b1;
		cy(pcsia_pkg::PCSIA_OP_NONE, 9'h000, 4'h8);
		chk(O_PAGE_PRESELECT_BIT, 1'b1);
		I_SRST = 1'b1;
		repeat (2) cy();
		chk({O_PAGE_PRESELECT_BIT, O_PC}, 11'h3ff);
		I_SRST = 1'b0;
		cy();
		chk(O_PC, 10'h000);
		cy(pcsia_pkg::PCSIA_OP_JUMP, 9'h123);
		chk(O_PC, 10'h123);
	endtask
	initial begin
		{I_SRST, I_CYCLE_EN, I_PAGE_VALUE} = 3'h6;
		{I_LOW_BYTE_DATA, I_POINTER_DATA, I_IND_WDATA} = 24'h000000;
		repeat (20) cy();
		I_SRST = 1'b0;
		t_flow();
		t_stack();
		t_low();
		ind(8'h07, 8'h5a, 1'b1, 8'h5a);
		ind(8'he0 | 8'h1f, 8'hc3, 1'b1, 8'hc3);
		ind(8'h00, 8'ha5, 1'b0, 8'h00);
		t_rst();
		end_sim();
	end
	initial begin
		#5000;
		num_errors++;
		end_sim();
	end
endmodule
`default_nettype wire
